// ==== src/power_selftest_ctrl.v ====
// Purpose: Power mode, self test and software reset control.
// Assumes: Register port on the same clock; one access per cycle.
// Notes:   A software reset reloads trim like a power-on reset.
`timescale 1ns/1ns
`default_nettype none
`include "power_ctrl_defs.vh"

module power_selftest_ctrl
#(
    parameter [7:0] REVISION = 8'hA0 // Arbitrary value.
)
(
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_r,
    // Filter setting written while measuring
    input wire hpf_wr,
    input wire [2:0] hpf_wdata,
    output reg [2:0] hpf_setting_r,
    // Datapath side
    input wire sample_ready_raw,
    output wire sample_ready_pin,
    output wire accel_enable,
    output wire temp_enable,
    output wire low_power,
    output reg digital_reset_r,
    output wire selftest_mode_enable,
    output wire selftest_force_enable,
    // Nonvolatile memory port
    output wire [2:0] nvm_addr,
    input wire [7:0] nvm_data,
    output wire trim_busy
);

// ----------------------------------------------------------------------
// Registers
// ----------------------------------------------------------------------

    reg [2:0] power_mode_control_r;
    reg [1:0] self_test_control_r;
    reg soft_reset_r;
    wire standby;
    wire [7:0] trim_data;
    wire [2:0] trim_idx;
    wire wr_power;
    wire wr_selftest;
    wire wr_reset_code;
    wire rd_trim_window;

    // Decodes a write to the given offset.
    function wr_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = (addr == ofs);
        end
    endfunction

    assign standby = power_mode_control_r[`BIT_STANDBY];

    // Write strobes per register; other offsets are ignored.
    assign wr_power = reg_wr && wr_hit(reg_addr, `OFS_POWER_MODE_CONTROL);
    assign wr_selftest = reg_wr && wr_hit(reg_addr, `OFS_SELF_TEST_CONTROL);

    // Only the exact code fires; any other byte to the trigger is dropped.
    assign wr_reset_code = reg_wr && reg_wdata == `SOFT_RESET_CODE
        && wr_hit(reg_addr, `OFS_SOFTWARE_RESET_TRIGGER);

    // The five shadow words sit at consecutive offsets.
    assign rd_trim_window = reg_addr >= `OFS_SHADOW_TRIM_FIRST
        && reg_addr <= `OFS_SHADOW_TRIM_LAST;

    // Power control; the reset code returns it to standby, and a write
    // in the reset cycle is lost because the device is restarting.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            power_mode_control_r <= `RST_POWER_MODE_CONTROL;
        end
        else if (soft_reset_r)
        begin
            power_mode_control_r <= `RST_POWER_MODE_CONTROL;
        end
        else if (wr_power)
        begin
            power_mode_control_r <= reg_wdata[2:0];
        end
    end

    // Self-test bits; only the two low bits are stored.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            self_test_control_r <= `RST_SELF_TEST_CONTROL;
        end
        else if (soft_reset_r)
        begin
            self_test_control_r <= `RST_SELF_TEST_CONTROL;
        end
        else if (wr_selftest)
        begin
            self_test_control_r <= reg_wdata[1:0];
        end
    end

    // Reset pulse, one cycle after the code is taken. A code taken in
    // the reset cycle itself starts another reset, so the set wins.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            soft_reset_r <= 1'b0;
        end
        else
        begin
            soft_reset_r <= wr_reset_code;
        end
    end

    // Filter setting; accepted in any mode, measuring included.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hpf_setting_r <= 3'h0;
        end
        else if (soft_reset_r)
        begin
            hpf_setting_r <= 3'h0;
        end
        else if (hpf_wr)
        begin
            hpf_setting_r <= hpf_wdata;
        end
    end

// ----------------------------------------------------------------------
// Mode outputs
// ----------------------------------------------------------------------

    // Digital reset held during standby and for a software reset.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            digital_reset_r <= 1'b1;
        end
        else
        begin
            digital_reset_r <= standby || soft_reset_r;
        end
    end

    assign low_power = standby;
    assign accel_enable = !standby;
    assign temp_enable = !standby
        && !power_mode_control_r[`BIT_TEMP_DISABLE];
    assign sample_ready_pin = sample_ready_raw && !standby
        && !power_mode_control_r[`BIT_READY_SUPPRESS];
    assign selftest_mode_enable = self_test_control_r[`BIT_SELFTEST_MODE];
    assign selftest_force_enable =
        self_test_control_r[`BIT_SELFTEST_FORCE];

// ----------------------------------------------------------------------
// Trim reload and read-back
// ----------------------------------------------------------------------

    assign trim_idx = reg_addr[2:0];

    trim_loader u_trim
    (
        .clock(clock),
        .resetn(resetn),
        .start(soft_reset_r),
        .nvm_addr_r(nvm_addr),
        .nvm_data(nvm_data),
        .rd_idx(trim_idx),
        .rd_data(trim_data),
        .busy_r(trim_busy)
    );

    // Read data; reserved bits and the write-only trigger read zero.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_r <= 8'h00;
        end
        else if (reg_rd)
        begin
            if (reg_addr == `OFS_POWER_MODE_CONTROL)
                reg_rdata_r <= {5'h00, power_mode_control_r};
            else if (reg_addr == `OFS_SELF_TEST_CONTROL)
                reg_rdata_r <= {6'h00, self_test_control_r};
            else if (reg_addr == `OFS_REVISION)
                reg_rdata_r <= REVISION;
            else if (rd_trim_window)
                reg_rdata_r <= trim_data;
            else
                reg_rdata_r <= 8'h00;
        end
    end

endmodule // power_selftest_ctrl

`default_nettype wire

// ==== pkg/power_ctrl_defs.vh ====
// Purpose: Offsets, field positions, reset values and counts for the
//          power, self-test and software reset control block.
// Assumes: Byte-wide registers on an internal register port.
// Notes:   Definitions only.
`ifndef POWER_CTRL_DEFS_VH
`define POWER_CTRL_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_POWER_MODE_CONTROL 8'h2D
`define OFS_SELF_TEST_CONTROL 8'h2E
`define OFS_SOFTWARE_RESET_TRIGGER 8'h2F
`define OFS_SHADOW_TRIM_FIRST 8'h50
`define OFS_SHADOW_TRIM_LAST 8'h54
`define OFS_REVISION 8'h01

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define BIT_STANDBY 0
`define BIT_TEMP_DISABLE 1
`define BIT_READY_SUPPRESS 2
`define BIT_SELFTEST_MODE 0
`define BIT_SELFTEST_FORCE 1
`define RST_POWER_MODE_CONTROL 3'h1
`define RST_SELF_TEST_CONTROL 2'h0
`define SOFT_RESET_CODE 8'h52

// ----------------------------------------------------------------------
// Trim reload
// ----------------------------------------------------------------------
`define TRIM_COUNT 3'h5
`define TRIM_IDX_W 3

`endif

// ==== src/trim_loader.v ====
// Purpose: Copies the five factory trim words from nonvolatile memory
//          into shadow registers after each reset.
// Assumes: Memory answers a read one cycle after the address.
// Notes:   Shadow contents are undefined until the load finishes.
`timescale 1ns/1ns
`default_nettype none
`include "power_ctrl_defs.vh"

module trim_loader
(
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Load request
    input wire start,
    // Nonvolatile memory port
    output reg [2:0] nvm_addr_r,
    input wire [7:0] nvm_data,
    // Shadow read port
    input wire [2:0] rd_idx,
    output wire [7:0] rd_data,
    output reg busy_r
);

    reg [7:0] shadow_r [0:4];
    reg fetch_r;
    reg [2:0] idx_r;

    // Shadow word lookup; out-of-range index reads zero.
    assign rd_data = (rd_idx < `TRIM_COUNT) ? shadow_r[rd_idx] : 8'h00;

    // Walks the trim words; a new start restarts the copy.
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_r <= 1'b1;
            fetch_r <= 1'b0;
            nvm_addr_r <= 3'h0;
            idx_r <= 3'h0;
        end
        else if (start)
        begin
            busy_r <= 1'b1;
            fetch_r <= 1'b0;
            nvm_addr_r <= 3'h0;
            idx_r <= 3'h0;
        end
        else if (busy_r)
        begin
            fetch_r <= 1'b1;
            if (fetch_r)
            begin
                shadow_r[idx_r] <= nvm_data;
                if (idx_r == `TRIM_COUNT - 3'h1)
                begin
                    busy_r <= 1'b0;
                    fetch_r <= 1'b0;
                end
                idx_r <= idx_r + 3'h1;
            end
            if (nvm_addr_r != `TRIM_COUNT - 3'h1)
            begin
                nvm_addr_r <= nvm_addr_r + 3'h1;
            end
        end
    end

endmodule // trim_loader

`default_nettype wire

// ==== bench/power_ctrl_props.sv ====
// Purpose: Port timing checks for the power control block.
// Assumes: One clock, reset active low.
// Notes: Bound to every instance.
`timescale 1ns/1ns
`default_nettype none
module power_ctrl_props
(
    // Watched ports
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic hpf_wr,
    input wire logic [2:0] hpf_wdata,
    input wire logic [2:0] hpf_setting_r,
    input wire logic sample_ready_raw,
    input wire logic sample_ready_pin,
    input wire logic accel_enable,
    input wire logic temp_enable,
    input wire logic low_power,
    input wire logic digital_reset_r,
    input wire logic selftest_mode_enable,
    input wire logic selftest_force_enable,
    input wire logic trim_busy
);
    // All checks share one clock and its reset.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic wr_pwr = reg_wr && reg_addr == 8'h2D;
    a_ready_gated: assert property (sample_ready_pin |->
        sample_ready_raw && !low_power) else $error("Ready not gated.");
    a_ready_suppress: assert property (wr_pwr && reg_wdata[2] |=>
        !sample_ready_pin) else $error("Ready not suppressed.");
    a_standby_halts: assert property (low_power |->
        !accel_enable && !temp_enable) else $error("Standby runs.");
    a_wake_up: assert property (wr_pwr && reg_wdata == 8'h00 |=>
        accel_enable && temp_enable) else $error("No wake up.");
    a_temp_off: assert property (wr_pwr && reg_wdata == 8'h02 |=>
        accel_enable && !temp_enable) else $error("Temp not off.");
    a_standby_reset: assert property ($rose(low_power) |->
        ##[0:1] digital_reset_r) else $error("No digital reset.");
    a_soft_reset: assert property (reg_wr && reg_addr == 8'h2F &&
        reg_wdata == 8'h52 |-> ##[1:3] (low_power && trim_busy))
        else $error("Soft reset missed.");
    a_hpf_any: assert property (hpf_wr |=>
        hpf_setting_r == $past(hpf_wdata)) else $error("Filter lost.");
    a_selftest_bits: assert property (reg_wr && reg_addr == 8'h2E
        |=> {selftest_force_enable, selftest_mode_enable} ==
        $past(reg_wdata[1:0])) else $error("Self test bits wrong.");
endmodule // power_ctrl_props
bind power_selftest_ctrl power_ctrl_props u_props (.*);
`default_nettype wire

// ==== bench/trim_nvm_model.sv ====
// Purpose: Trim memory beside the control block.
// Assumes: Data follows the address by one clock.
// Notes: Words past the fifth keep changing.
`timescale 1ns/1ns
`default_nettype none
module trim_nvm_model
(
    // Memory port
    input wire logic clock,
    input wire logic [2:0] nvm_addr,
    output logic [7:0] nvm_data
);
    initial nvm_data = 8'h5A;
    // Registered read one cycle after the address.
    always @(posedge clock)
    begin
        if (nvm_addr < 3'h5)
            nvm_data <= 8'hC3 + {5'h00, nvm_addr} * 8'h11;
        else
            nvm_data <= ~nvm_data;
    end
endmodule // trim_nvm_model
`default_nettype wire

// ==== bench/accel_power_selftest_reset_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the power control block.
// Assumes: Strobes last one clock.
// Notes: Register model held in bench variables.
`timescale 1ns/1ns
`default_nettype none
module accel_power_selftest_reset_ctrl_tb_top;
    logic clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic hpf_wr = 1'b0, sample_ready_raw = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, nvm_data, d, pwr, st;
    logic [2:0] hpf_wdata = 3'h0, nvm_addr, hpf_setting_r;
    logic [7:0] reg_rdata_r, trim_q [$];
    logic sample_ready_pin, accel_enable, temp_enable, low_power;
    logic digital_reset_r, selftest_mode_enable, selftest_force_enable;
    logic trim_busy;
    int error_cnt = 0, cmp_count = 0, i, j, k, m;
    power_selftest_ctrl u_dut (.*);
    trim_nvm_model u_nvm (.*);
    // Free running clock and hang guard.
    initial forever #10 clock = ~clock;
    initial
    begin
        #400000;
        error_cnt++;
        test_done;
    end
    task chk(input [7:0] g, input [7:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(posedge clock) #1;
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
        @(posedge clock) #1;
        reg_wr = 1'b0;
    endtask
    task rd(input [7:0] a);
        @(posedge clock) #1;
        {reg_rd, reg_addr} = {1'b1, a};
        @(posedge clock) #1;
        reg_rd = 1'b0;
        d = reg_rdata_r;
    endtask
    task ports;
        chk({low_power, accel_enable, temp_enable, sample_ready_pin,
            selftest_force_enable, selftest_mode_enable}, {2'b00, pwr[0],
            ~pwr[0], ~pwr[0] & ~pwr[1], sample_ready_raw & ~pwr[0] &
            ~pwr[2], st[1:0]});
    endtask
    task wait_trim;
        repeat (3) @(posedge clock);
        for (k = 0; k < 50 && trim_busy !== 1'b0; k++) @(posedge clock);
        #1 chk({7'h00, trim_busy}, 8'h00);
        chk({5'h00, nvm_addr}, 8'h04);
    endtask
    task test_done;
        $display("Mismatches %0d, comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence: reset values, random settings, soft reset.
    initial
    begin
        k = $urandom(32'hA0F3);
        repeat (20) @(posedge clock);
        #1 resetn = 1'b1;
        pwr = 8'h01;
        st = 8'h00;
        rd(8'h2D);
        chk(d, pwr);
        rd(8'h2E);
        chk(d, st);
        rd(8'h2F);
        chk(d, 8'h00);
        rd(8'h10);
        chk(d, 8'h00);
        rd(8'h01);
        chk(d, 8'hA0);
        ports;
        chk({7'h00, digital_reset_r}, 8'h01);
        wait_trim;
        for (i = 0; i < 5; i++)
        begin
            rd(8'h50 + i);
            chk(d, 8'hC3 + i * 8'h11);
            trim_q.push_back(d);
        end
        // Settings change only in standby; the last write leaves it only when bit 0 of d is clear.
        for (i = 0; i < 24; i++)
        begin
            sample_ready_raw = $urandom;
            wr(8'h2D, pwr | 8'h01);
            d = $urandom;
            wr(8'h2D, d | 8'h01);
            st = $urandom;
            wr(8'h2E, st);
            wr(8'h2D, d);
            pwr = d & 8'h07;
            st = st & 8'h03;
            ports;
            rd(8'h2D);
            chk(d, pwr);
            rd(8'h2E);
            chk(d, st);
            chk({7'h00, digital_reset_r}, {7'h00, pwr[0]});
        end
        wr(8'h2D, pwr | 8'h01);
        wr(8'h2D, 8'h01);
        pwr = 8'h00;
        wr(8'h2D, pwr);
        ports;
        hpf_wdata = $urandom;
        hpf_wr = 1'b1;
        @(posedge clock) #1 hpf_wr = 1'b0;
        chk(hpf_setting_r, hpf_wdata);
        wr(8'h2D, 8'h01);
        wr(8'h2D, 8'h03);
        pwr = 8'h02;
        wr(8'h2D, pwr);
        ports;
        wr(8'h2F, 8'h51);
        rd(8'h2D);
        chk(d, pwr);
        for (i = 0; i < 5; i++)
        begin
            wr(8'h2F, 8'h52);
            wait_trim;
            m = 0;
            for (j = 0; j < 5; j++)
            begin
                rd(8'h50 + j);
                m += d !== trim_q[j];
            end
            if (m == 0)
                break;
        end
        chk(m, 0);
        pwr = 8'h01;
        st = 8'h00;
        rd(8'h2D);
        chk(d, pwr);
        rd(8'h2E);
        chk(d, st);
        ports;
        chk({7'h00, digital_reset_r}, 8'h01);
        test_done;
    end
endmodule // accel_power_selftest_reset_ctrl_tb_top
`default_nettype wire
